// file: inc/csk_pkg.sv
// shared constants and types of the conditional-skip execution block
// assumes one clock domain; memory and ports live outside the block
//
// Summary of operation
// RQ1 - skip_if_equal compares work_register with an immediate or memory byte and skips on match.
// RQ2 - every compare sets null, borrow, half-borrow and signed-range flags as a subtraction would.
// RQ3 - skip_if_unequal with a memory byte skips the next instruction when the values differ.
// RQ4 - skip_if_unequal with an immediate skips the next instruction when the values differ.
// RQ5 - bit tests on an IO port bit skip on low or high and leave all four flags alone.
// RQ6 - bit tests on a memory bit skip on low or high and leave all four flags alone.
// RQ7 - inc_skip_if_zero on work_register adds one, writes back, sets flags, skips on zero.
// RQ8 - dec_skip_if_zero on work_register subtracts one, writes back, sets flags, skips on zero.
// RQ9 - inc_skip_if_zero on a memory byte increments it in place, sets flags, skips on zero.
// RQ10 - dec_skip_if_zero on a memory byte decrements it in place, sets flags, skips on zero.
// RQ11 - a skipped instruction is cancelled and changes no register, memory, port or flag.
package csk_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned BSEL_W = 3;
  localparam int unsigned FLAG_W = 4;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] REG_WORK = 4'h0;
  localparam logic [3:0] REG_FLAGS = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_CTRL = 4'hc;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned FLAG_NULL = 0;
  localparam int unsigned FLAG_BORROW = 1;
  localparam int unsigned FLAG_HALF = 2;
  localparam int unsigned FLAG_RANGE = 3;
  localparam int unsigned STAT_PEND = 0;
  localparam int unsigned STAT_CANC = 1;
  localparam int unsigned CTRL_SKIP_EN = 0;

  // ----------------------------------------
  // reset values and fixed operand values
  // ----------------------------------------
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [0:0] CTRL_RST = 1'h1;
  localparam logic [7:0] ONE_VAL = 8'h01;
  localparam logic [7:0] ZERO_VAL = 8'h00;

  // ----------------------------------------
  // instruction codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NOP,
    OP_CEQ_IMM,
    OP_CEQ_MEM,
    OP_CNE_MEM,
    OP_CNE_IMM,
    OP_T0_IO,
    OP_T1_IO,
    OP_T0_MEM,
    OP_T1_MEM,
    OP_INC_A,
    OP_DEC_A,
    OP_INC_M,
    OP_DEC_M
  } csk_op_e;

endpackage : csk_pkg

// file: design/csk_alu.sv
// 8-bit adder/subtractor with the four status flags
// purely combinational; caller registers the results
`timescale 1ns/1ps
module csk_alu #(
  parameter int unsigned W = csk_pkg::DATA_W
) (
  input wire logic [W-1:0] i_a, // left operand
  input wire logic [W-1:0] i_b, // right operand
  input wire logic i_sub, // 1 subtracts b from a
  output logic [W-1:0] o_res, // result
  output logic [csk_pkg::FLAG_W-1:0] o_flags // null, borrow, half, range
);

  logic [W:0] full;
  logic [4:0] low;
  logic [W-1:0] b_eff;

  always_comb begin
    // subtract as a + ~b + 1; borrow is the inverted carry
    b_eff = i_sub ? ~i_b : i_b;
    full = {1'b0, i_a} + {1'b0, b_eff} + {{W{1'b0}}, i_sub};
    low = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, i_sub};
    o_res = full[W-1:0];
    o_flags[csk_pkg::FLAG_NULL] = (full[W-1:0] == '0);
    o_flags[csk_pkg::FLAG_BORROW] = full[W] ^ i_sub;
    o_flags[csk_pkg::FLAG_HALF] = low[4] ^ i_sub;
    o_flags[csk_pkg::FLAG_RANGE] = (i_a[W-1] == b_eff[W-1]) && (full[W-1] != i_a[W-1]);
  end

endmodule : csk_alu

// file: design/csk_skip.sv
// skip tracker: remembers that the next instruction must be cancelled
// set and consume come from the same clock domain
`timescale 1ns/1ps
module csk_skip (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_ce, // clock enable
  input wire logic i_exec, // an instruction is offered
  input wire logic i_set, // condition held for the current instruction
  output logic o_pend, // next instruction will be cancelled
  output logic o_cancel // current instruction is being cancelled
);

  logic pend_r;
  logic pend_nxt;

  always_comb begin
    o_cancel = i_exec && pend_r;
    pend_nxt = pend_r;
    // a cancelled instruction consumes the pending skip and sets nothing
    if (o_cancel) begin
      pend_nxt = 1'b0; // [RQ11]
    end else if (i_exec) begin
      pend_nxt = i_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_r <= 1'b0;
    end else if (i_ce) begin
      pend_r <= pend_nxt;
    end
  end

  assign o_pend = pend_r;

endmodule : csk_skip

// file: design/csk_core.sv
// conditional-skip execution unit of a small 8-bit core
// assumes memory read data are valid in the cycle of I_EXEC and IO pins are asynchronous
`timescale 1ns/1ps
module csk_core (
  input wire logic I_MCLK, // system clock, 25 MHz
  input wire logic I_RESET_N, // async reset, active low
  input wire logic I_CE, // clock enable, freezes all state when low
  input wire logic I_EXEC, // one-cycle: instruction offered
  input wire csk_pkg::csk_op_e I_OP, // instruction code
  input wire logic [7:0] I_IMM, // immediate operand
  input wire logic [2:0] I_BSEL, // bit number for bit tests
  input wire logic [7:0] I_MEM_RDATA, // memory byte at the operand address
  input wire logic [7:0] I_IO_PINS, // IO port pin levels, asynchronous
  input wire logic [3:0] I_ADDR, // register address
  input wire logic [7:0] I_WDATA, // register write data
  input wire logic I_WR, // register write strobe
  input wire logic I_RD, // register read strobe
  output logic [7:0] O_RDATA, // register read data, cycle after I_RD
  output logic O_MEM_WE, // one-cycle memory write back
  output logic [7:0] O_MEM_WDATA, // memory write data
  output logic [7:0] O_WORK, // work_register
  output logic [3:0] O_FLAGS, // flag register
  output logic O_SKIP_PEND, // next instruction will be cancelled
  output logic O_CANCELLED // one-cycle: last instruction was cancelled
);

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic [7:0] io_meta_r;
  logic [7:0] io_sync_r;

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      io_meta_r <= '0;
      io_sync_r <= '0;
    end else if (I_CE) begin
      io_meta_r <= I_IO_PINS;
      io_sync_r <= io_meta_r;
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] work_r;
  logic [7:0] work_nxt;
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic skip_en_r;
  logic skip_en_nxt;
  logic canc_r;
  logic canc_nxt;
  logic mem_we_r;
  logic mem_we_nxt;
  logic [7:0] mem_wd_r;
  logic [7:0] mem_wd_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic alu_sub;
  logic [7:0] alu_res;
  logic [3:0] alu_flags;
  logic cond;
  logic run;
  logic cancel;
  logic pend;

  function automatic logic bit_of(input logic [7:0] v, input logic [2:0] n);
    bit_of = v[n];
  endfunction : bit_of

  csk_alu #(
    .W(csk_pkg::DATA_W)
  ) u_alu (
    .i_a(alu_a),
    .i_b(alu_b),
    .i_sub(alu_sub),
    .o_res(alu_res),
    .o_flags(alu_flags)
  );

  csk_skip u_skip (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESET_N),
    .i_ce(I_CE),
    .i_exec(I_EXEC),
    .i_set(cond && skip_en_r),
    .o_pend(pend),
    .o_cancel(cancel)
  );

  assign run = I_EXEC && !cancel; // [RQ11]

  // operand selection and skip condition
  always_comb begin
    alu_a = work_r;
    alu_b = I_IMM;
    alu_sub = 1'b1;
    cond = 1'b0;
    unique case (I_OP)
      csk_pkg::OP_CEQ_IMM: begin
        cond = (work_r == I_IMM); // [RQ1]
      end
      csk_pkg::OP_CEQ_MEM: begin
        alu_b = I_MEM_RDATA;
        cond = (work_r == I_MEM_RDATA); // [RQ1]
      end
      csk_pkg::OP_CNE_MEM: begin
        alu_b = I_MEM_RDATA;
        cond = (work_r != I_MEM_RDATA); // [RQ3]
      end
      csk_pkg::OP_CNE_IMM: begin
        cond = (work_r != I_IMM); // [RQ4]
      end
      csk_pkg::OP_T0_IO: begin
        cond = !bit_of(io_sync_r, I_BSEL); // [RQ5]
      end
      csk_pkg::OP_T1_IO: begin
        cond = bit_of(io_sync_r, I_BSEL); // [RQ5]
      end
      csk_pkg::OP_T0_MEM: begin
        cond = !bit_of(I_MEM_RDATA, I_BSEL); // [RQ6]
      end
      csk_pkg::OP_T1_MEM: begin
        cond = bit_of(I_MEM_RDATA, I_BSEL); // [RQ6]
      end
      csk_pkg::OP_INC_A: begin
        alu_b = csk_pkg::ONE_VAL;
        alu_sub = 1'b0;
        cond = (alu_res == csk_pkg::ZERO_VAL); // [RQ7]
      end
      csk_pkg::OP_DEC_A: begin
        alu_b = csk_pkg::ONE_VAL;
        cond = (alu_res == csk_pkg::ZERO_VAL); // [RQ8]
      end
      csk_pkg::OP_INC_M: begin
        alu_a = I_MEM_RDATA;
        alu_b = csk_pkg::ONE_VAL;
        alu_sub = 1'b0;
        cond = (alu_res == csk_pkg::ZERO_VAL); // [RQ9]
      end
      csk_pkg::OP_DEC_M: begin
        alu_a = I_MEM_RDATA;
        alu_b = csk_pkg::ONE_VAL;
        cond = (alu_res == csk_pkg::ZERO_VAL); // [RQ10]
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // next-state for architectural state
  // ----------------------------------------
  always_comb begin
    work_nxt = work_r;
    flags_nxt = flags_r;
    skip_en_nxt = skip_en_r;
    mem_we_nxt = 1'b0;
    mem_wd_nxt = mem_wd_r;
    canc_nxt = I_EXEC && cancel; // [RQ11]
    // software writes first so an instruction in the same cycle wins
    if (I_WR) begin
      unique case (I_ADDR)
        csk_pkg::REG_WORK: work_nxt = I_WDATA;
        csk_pkg::REG_FLAGS: flags_nxt = I_WDATA[3:0];
        csk_pkg::REG_CTRL: skip_en_nxt = I_WDATA[csk_pkg::CTRL_SKIP_EN];
        default: skip_en_nxt = skip_en_r;
      endcase
    end
    if (run) begin
      unique case (I_OP)
        csk_pkg::OP_CEQ_IMM, csk_pkg::OP_CEQ_MEM,
        csk_pkg::OP_CNE_MEM, csk_pkg::OP_CNE_IMM: begin
          flags_nxt = alu_flags; // [RQ2]
        end
        csk_pkg::OP_INC_A, csk_pkg::OP_DEC_A: begin
          work_nxt = alu_res; // [RQ7] [RQ8]
          flags_nxt = alu_flags;
        end
        csk_pkg::OP_INC_M, csk_pkg::OP_DEC_M: begin
          mem_we_nxt = 1'b1; // [RQ9] [RQ10]
          mem_wd_nxt = alu_res;
          flags_nxt = alu_flags;
        end
        default: begin
          // bit tests and no-op leave flags untouched
          flags_nxt = flags_nxt; // [RQ5] [RQ6]
        end
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      work_r <= csk_pkg::WORK_RST;
      flags_r <= csk_pkg::FLAGS_RST;
      skip_en_r <= csk_pkg::CTRL_RST[0];
      canc_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_wd_r <= csk_pkg::ZERO_VAL;
    end else if (I_CE) begin
      work_r <= work_nxt;
      flags_r <= flags_nxt;
      skip_en_r <= skip_en_nxt;
      canc_r <= canc_nxt;
      mem_we_r <= mem_we_nxt;
      mem_wd_r <= mem_wd_nxt;
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always_comb begin
    rdata_nxt = csk_pkg::ZERO_VAL;
    // unmapped addresses read zero; data stand only one cycle
    if (I_RD) begin
      unique case (I_ADDR)
        csk_pkg::REG_WORK: rdata_nxt = work_r;
        csk_pkg::REG_FLAGS: rdata_nxt = {4'h0, flags_r};
        csk_pkg::REG_STATUS: begin
          rdata_nxt[csk_pkg::STAT_PEND] = pend;
          rdata_nxt[csk_pkg::STAT_CANC] = canc_r;
        end
        csk_pkg::REG_CTRL: rdata_nxt = {7'h00, skip_en_r};
        default: rdata_nxt = csk_pkg::ZERO_VAL;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rdata_r <= csk_pkg::ZERO_VAL;
    end else if (I_CE) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign O_RDATA = rdata_r;
  assign O_MEM_WE = mem_we_r;
  assign O_MEM_WDATA = mem_wd_r;
  assign O_WORK = work_r;
  assign O_FLAGS = flags_r;
  assign O_SKIP_PEND = pend;
  assign O_CANCELLED = canc_r;

endmodule : csk_core

// file: bench/csk_core_checker.sv
// concurrent checks of the conditional-skip unit
// sees only the core's ports; one clock, async active-low reset
`timescale 1ns/1ps
module csk_core_checker (
  input wire logic I_MCLK, // clock
  input wire logic I_RESET_N, // reset, active low
  input wire logic I_CE, // clock enable
  input wire logic I_EXEC, // instruction offered
  input wire csk_pkg::csk_op_e I_OP, // code
  input wire logic [7:0] I_IMM, // immediate
  input wire logic [7:0] I_MEM_RDATA, // memory byte
  input wire logic I_WR, // write strobe
  input wire logic O_MEM_WE, // write back
  input wire logic [7:0] O_MEM_WDATA, // new byte
  input wire logic [7:0] O_WORK, // work_register
  input wire logic [3:0] O_FLAGS, // flags
  input wire logic O_SKIP_PEND, // skip pending
  input wire logic O_CANCELLED // cancel pulse
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  logic go;
  // software writes excluded: they could legally move work or flags
  assign go = I_CE && I_EXEC && !O_SKIP_PEND && !I_WR;
  cancel_pulse_a: assert property (I_CE && I_EXEC && O_SKIP_PEND
    |=> O_CANCELLED && !O_SKIP_PEND && !O_MEM_WE) else $error("bad cancel");
  cancel_hold_a: assert property (I_CE && I_EXEC && O_SKIP_PEND && !I_WR
    |=> $stable(O_WORK) && $stable(O_FLAGS)) else $error("cancel changed state");
  equal_flags_a: assert property (go && I_OP == csk_pkg::OP_CEQ_IMM && O_WORK == I_IMM
    |=> O_FLAGS[1:0] == 2'b01) else $error("equal compare flags");
  unequal_flags_a: assert property (go && I_OP == csk_pkg::OP_CNE_IMM
    |=> O_FLAGS[1:0] == {$past(O_WORK) < $past(I_IMM), $past(O_WORK) == $past(I_IMM)})
    else $error("unequal compare flags");
  mem_compare_a: assert property (go && I_OP inside {csk_pkg::OP_CEQ_MEM, csk_pkg::OP_CNE_MEM}
    |=> O_FLAGS[0] == ($past(O_WORK) == $past(I_MEM_RDATA))) else $error("memory compare");
  bit_test_a: assert property (go && I_OP inside {[csk_pkg::OP_T0_IO:csk_pkg::OP_T1_MEM]}
    |=> $stable(O_FLAGS) && $stable(O_WORK)) else $error("bit test changed state");
  inc_work_a: assert property (go && I_OP == csk_pkg::OP_INC_A
    |=> O_WORK == $past(O_WORK) + 8'h01) else $error("work increment");
  dec_work_a: assert property (go && I_OP == csk_pkg::OP_DEC_A
    |=> O_WORK == $past(O_WORK) - 8'h01) else $error("work decrement");
  inc_mem_a: assert property (go && I_OP == csk_pkg::OP_INC_M
    |=> O_MEM_WE && O_MEM_WDATA == $past(I_MEM_RDATA) + 8'h01) else $error("memory increment");
  dec_mem_a: assert property (go && I_OP == csk_pkg::OP_DEC_M
    |=> O_MEM_WE && O_MEM_WDATA == $past(I_MEM_RDATA) - 8'h01) else $error("memory decrement");
endmodule : csk_core_checker

bind csk_core csk_core_checker chk (.I_MCLK, .I_RESET_N, .I_CE, .I_EXEC, .I_OP, .I_IMM,
  .I_MEM_RDATA, .I_WR, .O_MEM_WE, .O_MEM_WDATA, .O_WORK, .O_FLAGS, .O_SKIP_PEND, .O_CANCELLED);

// file: bench/csk_core_tb.sv
// self-checking bench of the conditional-skip unit
// drives all ports itself; clock enable dropped once right after a cancel
`timescale 1ns/1ps
module csk_core_tb;
  logic I_MCLK, I_RESET_N, I_CE, I_EXEC, I_WR, I_RD, O_MEM_WE, O_SKIP_PEND, O_CANCELLED;
  csk_pkg::csk_op_e I_OP;
  logic [7:0] I_IMM, I_MEM_RDATA, I_IO_PINS, I_WDATA, O_RDATA, O_MEM_WDATA, O_WORK, m;
  logic [2:0] I_BSEL;
  logic [3:0] I_ADDR, O_FLAGS, flg;
  logic [31:0] v;
  logic [7:0] work;
  logic pend, sken;
  int err_count, checks;
  integer seed;
  csk_core uut (.I_MCLK, .I_RESET_N, .I_CE, .I_EXEC, .I_OP, .I_IMM, .I_BSEL,
    .I_MEM_RDATA, .I_IO_PINS, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_MEM_WE,
    .O_MEM_WDATA, .O_WORK, .O_FLAGS, .O_SKIP_PEND, .O_CANCELLED);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // returns {range, half, borrow/carry, null, result}
  function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] b, input logic s);
    logic [8:0] r;
    logic h;
    r = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    h = s ? (a[3:0] < b[3:0]) : (({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f);
    return {(a[7] ^ b[7] ^ !s) && (r[7] != a[7]), h, r[8], r[7:0] == 8'h00, r[7:0]};
  endfunction : alu
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge I_MCLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge I_MCLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    #1;
    check("rdata", O_RDATA, exp);
  endtask : rd
  task automatic exec(input int op, input logic [7:0] imm, input logic [7:0] mem,
                      input logic [2:0] b);
    logic [11:0] f;
    logic cond, we, canc;
    logic [7:0] md;
    cond = 1'b0;
    we = 1'b0;
    md = 8'h00;
    canc = pend;
    if (!pend) begin
      case (op)
        1, 2, 3, 4: begin
          f = alu(work, (op == 1 || op == 4) ? imm : mem, 1'b1);
          flg = f[11:8];
          cond = f[8] ^ (op > 2);
        end
        5, 6: cond = I_IO_PINS[b] == (op == 6);
        7, 8: cond = mem[b] == (op == 8);
        9, 10, 11, 12: begin
          f = alu(op < 11 ? work : mem, 8'h01, !op[0]);
          flg = f[11:8];
          cond = f[8];
          if (op < 11) work = f[7:0];
          else begin
            we = 1'b1;
            md = f[7:0];
          end
        end
        default: ;
      endcase
    end
    pend = cond && sken;
    @(posedge I_MCLK);
    I_EXEC <= 1'b1;
    I_OP <= csk_pkg::csk_op_e'(op);
    I_IMM <= imm;
    I_MEM_RDATA <= mem;
    I_BSEL <= b;
    @(posedge I_MCLK);
    I_EXEC <= 1'b0;
    #1;
    check("work", O_WORK, work);
    check("flags", 8'(O_FLAGS), 8'(flg));
    check("skip", 8'(O_SKIP_PEND), 8'(pend));
    check("cancel", 8'(O_CANCELLED), 8'(canc));
    check("mem we", 8'(O_MEM_WE), 8'(we));
    if (we) check("mem data", O_MEM_WDATA, md);
  endtask : exec
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    I_MCLK = 1'b0;
    forever #20 I_MCLK = ~I_MCLK;
  end
  // about sixteen times the expected run
  initial begin
    #2000000;
    err_count++;
    stop_test();
  end
  initial begin
    seed = 32'hb733;
    I_RESET_N = 1'b0;
    I_CE = 1'b1;
    I_EXEC = 1'b0;
    I_WR = 1'b0;
    I_RD = 1'b0;
    I_OP = csk_pkg::OP_NOP;
    I_IMM = 8'h00;
    I_BSEL = 3'h0;
    I_MEM_RDATA = 8'h00;
    I_IO_PINS = 8'h00;
    I_ADDR = 4'h0;
    I_WDATA = 8'h00;
    err_count = 0;
    checks = 0;
    work = 8'h00;
    flg = 4'h0;
    pend = 1'b0;
    sken = 1'b1;
    repeat (6) @(posedge I_MCLK);
    I_RESET_N <= 1'b1;
    rd(csk_pkg::REG_CTRL, 8'h01);
    rd(4'h2, 8'h00);
    wr(csk_pkg::REG_STATUS, 8'hff);
    rd(csk_pkg::REG_STATUS, 8'h00);
    $display("registers done");
    work = 8'h55;
    wr(csk_pkg::REG_WORK, work);
    exec(1, 8'h55, 8'h00, 3'h0);
    exec(9, 8'h00, 8'h00, 3'h0);
    work = 8'hff;
    wr(csk_pkg::REG_WORK, work);
    exec(9, 8'h00, 8'h00, 3'h0);
    exec(12, 8'h00, 8'h01, 3'h0);
    exec(12, 8'h00, 8'h01, 3'h0);
    exec(11, 8'h00, 8'hff, 3'h0);
    // enable low for one edge: the offered increment and the cancel pulse must both freeze
    I_CE <= 1'b0;
    I_EXEC <= 1'b1;
    I_OP <= csk_pkg::OP_INC_A;
    @(posedge I_MCLK);
    I_CE <= 1'b1;
    I_EXEC <= 1'b0;
    I_RD <= 1'b1;
    I_ADDR <= csk_pkg::REG_STATUS;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    #1;
    check("frozen work", O_WORK, work);
    check("frozen flags", 8'(O_FLAGS), 8'(flg));
    check("frozen status", O_RDATA, 8'(1 << csk_pkg::STAT_CANC));
    $display("corner cases done");
    for (int i = 0; i < 600; i++) begin
      if (i == 300) begin
        sken = 1'b0;
        wr(csk_pkg::REG_CTRL, 8'h00);
        rd(csk_pkg::REG_CTRL, 8'h00);
      end
      v = $random(seed);
      I_IO_PINS <= v[15:8];
      if (v[1:0] == 2'b00) begin
        work = v[9] ? v[23:16] : (v[8] ? 8'hff : 8'h01);
        wr(csk_pkg::REG_WORK, work);
      end
      if (v[3:2] == 2'b00) begin
        flg = v[27:24];
        wr(csk_pkg::REG_FLAGS, 8'(flg));
      end
      // pins need two enabled edges through the synchroniser
      repeat (2) @(posedge I_MCLK);
      v = $random(seed);
      m = v[5] ? (v[4] ? 8'h01 : 8'hff) : (v[4] ? work : v[23:16]);
      exec(int'(v[31:28]), v[6] ? work : v[15:8], m, v[2:0]);
      if (i % 50 == 0) begin
        rd(csk_pkg::REG_FLAGS, 8'(flg));
        rd(csk_pkg::REG_WORK, work);
        rd(csk_pkg::REG_STATUS, 8'(pend));
      end
    end
    $display("random instructions done");
    stop_test();
  end
endmodule : csk_core_tb
